// [shared/cs_unit_pkg.sv]
/*
 * Constants for the external chip-select unit: register indices, field
 * positions, reset values and the cycle state encoding.
 * Assumes an APB register port whose byte address is four times the index.
 */
`default_nettype none

package cs_unit_pkg;

   localparam int NUM_BANKS = 4;
   localparam int APB_AW = 12;
   localparam int IDX_W = 10;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] BASE_IDX [NUM_BANKS] =
      '{10'h080, 10'h08C, 10'h098, 10'h0A4};
   localparam logic [IDX_W-1:0] MASK_IDX [NUM_BANKS] =
      '{10'h084, 10'h090, 10'h09C, 10'h0A8};
   localparam logic [IDX_W-1:0] CTRL_IDX [NUM_BANKS] =
      '{10'h088, 10'h094, 10'h0A2, 10'h0AE};
   localparam logic [IDX_W-1:0] ATA_CFG_IDX = 10'h0B0;

   // Mask register fields
   localparam int MASK_VALID_BIT = 0;
   localparam int MASK_WP_BIT = 8;
   localparam int MASK_LO = 16;

   // Control register fields
   localparam int CTRL_WS_LO = 10;
   localparam int CTRL_WS_W = 4;
   localparam int CTRL_AA_BIT = 8;
   localparam int CTRL_PS_LO = 6;
   localparam int CTRL_BEM_BIT = 5;
   localparam int CTRL_BSTR_BIT = 4;
   localparam int CTRL_BSTW_BIT = 3;
   localparam logic [1:0] PS_16BIT = 2'h2;

   // Boot bank control after reset: auto acknowledge, 15 waits, 16-bit port
   localparam logic [15:0] CTRL0_RESET = 16'h3DA0;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] BASE_RESET = 16'h0000;
   localparam logic [31:0] MASK_RESET = 32'h0000_0000;
   localparam logic [15:0] ATA_CFG_RESET = 16'h0000;
   localparam logic [31:0] ATA_CFG_USED = 32'h0000_3776;

   // ata_config_one fields
   localparam int CFG_IDE_SPLIT_BIT = 1;
   localparam int CFG_CARD_SPLIT_BIT = 2;
   localparam int CFG_BUF1_LO = 4;
   localparam int CFG_BUF2_LO = 8;
   localparam int CFG_READY_LO = 12;

   localparam int BOOT_BANK = 0;
   localparam int IDE_BANK = 2;
   localparam int CARD_BANK = 3;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_DONE = 2'b11
   } cyc_state_t;

endpackage : cs_unit_pkg

`default_nettype wire

// [rtl/cs_unit.sv]
/*
 * External chip-select unit: bank decode, wait-state timing, AT-bus
 * strobes, read output enable and bus-buffer enables, with an APB slave
 * holding the base, mask and control registers of the four banks.
 * Assumes the bus side raises bus_start_i for one cycle with address and
 * direction valid and held until cycle_done_o or cycle_error_o.
 */
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Four selects, two buffer enables, one read enable
// - Masking gives 64KB to 4GB bank sizes
// - After reset every cycle selects boot bank
// - Only boot bank configured at reset
// - Reset clears second bank programming entirely
// - Second bank fully programmable, all fields
// - IDE strobes shared or split by configuration
// - IDE strobes allow over 16 waits
// - IDE cycles end on ready input
// - Card bank same features, same strobe option
// - Card strobes: over 16 waits, ready termination
// - Read enable changes on falling clock edges
// - Read enable only when a bank matches
// - Boot cycles: buffer one on, two off
// - Software picks buffer enables per other bank
// - Ready waits only on IDE and card banks
// - Base 16, mask 32, control 16 bits
// - Control sets width, waits, acknowledge; burst bits held only
// - Base sets start, mask sets size, attributes
// - No match ends cycle in error
// - Single match runs by its control register
// - Multiple match goes external, ends on acknowledge
// - Boot bank global after reset, relocatable
// - Boot control resets to acknowledge, 15 waits, 16-bit
// - Global until boot valid bit, only reset restores
// - Base compared with upper address bits

module cs_unit (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [cs_unit_pkg::APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic bus_start_i,
   input wire logic [31:0] bus_addr_i,
   input wire logic bus_write_i,
   input wire logic ready_i,
   input wire logic transfer_acknowledge_pin_n_i,
   output logic boot_select_n_o,
   output logic second_select_n_o,
   output logic ide_bank_select_n_o,
   output logic card_bank_select_n_o,
   output logic ide_read_strobe_n_o,
   output logic ide_write_strobe_n_o,
   output logic card_read_strobe_n_o,
   output logic card_write_strobe_n_o,
   output logic read_oe_n_o,
   output logic first_buffer_enable_n_o,
   output logic second_buffer_enable_n_o,
   output logic [1:0] port_width_o,
   output logic cycle_done_o,
   output logic cycle_error_o
);

   localparam int NB = cs_unit_pkg::NUM_BANKS;
   localparam int WSW = cs_unit_pkg::CTRL_WS_W;

   ////////////////////////////////////////////////////////////////////////
   // Register file

   logic [15:0] bank_base_register [NB];
   logic [31:0] bank_mask_register [NB];
   logic [15:0] bank_control_register [NB];
   logic [15:0] ata_config_one;
   logic boot_global;

   wire [cs_unit_pkg::IDX_W-1:0] reg_idx = paddr_i[cs_unit_pkg::APB_AW-1:2];
   wire apb_access = psel_i & penable_i & ~pready_o;
   wire apb_wr = apb_access & pwrite_i;
   wire hit_cfg = (reg_idx == cs_unit_pkg::ATA_CFG_IDX);
   wire [NB-1:0] hit_base;
   wire [NB-1:0] hit_mask;
   wire [NB-1:0] hit_ctrl;
   wire [31:0] rd_term [NB+1];

   assign rd_term[0] = hit_cfg ? {16'h0000, ata_config_one} : 32'h0000_0000;

   genvar g;
   generate
      for (g = 0; g < NB; g++) begin : g_regs
         assign hit_base[g] = (reg_idx == cs_unit_pkg::BASE_IDX[g]);
         assign hit_mask[g] = (reg_idx == cs_unit_pkg::MASK_IDX[g]);
         assign hit_ctrl[g] = (reg_idx == cs_unit_pkg::CTRL_IDX[g]);
         assign rd_term[g+1] = rd_term[g]
            | (hit_base[g] ? {bank_base_register[g], 16'h0000} : 32'h0000_0000)
            | (hit_mask[g] ? bank_mask_register[g] : 32'h0000_0000)
            | (hit_ctrl[g] ? {16'h0000, bank_control_register[g]}
                           : 32'h0000_0000);

         // Every bank resets to unprogrammed except the boot bank control
         always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
               bank_base_register[g] <= cs_unit_pkg::BASE_RESET;
               bank_mask_register[g] <= cs_unit_pkg::MASK_RESET;
               bank_control_register[g] <= (g == cs_unit_pkg::BOOT_BANK) ?
                  cs_unit_pkg::CTRL0_RESET : cs_unit_pkg::CTRL_RESET;
            end else if (apb_wr) begin
               // Base holds the upper address half only
               if (hit_base[g]) begin
                  bank_base_register[g] <= pwdata_i[31:16];
               end
               if (hit_mask[g]) begin
                  bank_mask_register[g] <= pwdata_i;
               end
               if (hit_ctrl[g]) begin
                  bank_control_register[g] <= pwdata_i[15:0];
               end
            end
         end
      end
   endgenerate

   wire any_hit = hit_cfg | (|hit_base) | (|hit_mask) | (|hit_ctrl);

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ata_config_one <= cs_unit_pkg::ATA_CFG_RESET;
      end else if (apb_wr && hit_cfg) begin
         ata_config_one <= pwdata_i[15:0] & cs_unit_pkg::ATA_CFG_USED[15:0];
      end
   end

   // Leaving global mode is one-way; only reset brings it back
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         boot_global <= 1'b1;
      end else if (bank_mask_register[cs_unit_pkg::BOOT_BANK]
                   [cs_unit_pkg::MASK_VALID_BIT]) begin
         boot_global <= 1'b0;
      end
   end

   // One wait state in the access phase, so read data comes from a flop
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= apb_access;
         prdata_o <= (apb_access && !pwrite_i) ? rd_term[NB] : 32'h0000_0000;
         pslverr_o <= apb_access & ~any_hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   wire [NB-1:0] bank_hit;
   generate
      for (g = 0; g < NB; g++) begin : g_dec
         // Mask bits set are don't-care, widening the block up to 4 GB
         wire [15:0] care = ~bank_mask_register[g][31:cs_unit_pkg::MASK_LO];
         wire addr_eq = ((bus_addr_i[31:16] ^ bank_base_register[g]) & care)
                        == 16'h0000;
         wire wp_block = bus_write_i &
                         bank_mask_register[g][cs_unit_pkg::MASK_WP_BIT];
         assign bank_hit[g] = addr_eq & ~wp_block &
            bank_mask_register[g][cs_unit_pkg::MASK_VALID_BIT];
      end
   endgenerate

   // Global mode forces the boot bank alone, whatever the address
   wire [NB-1:0] boot_only = 4'b0001;
   wire [NB-1:0] match = boot_global ? boot_only : bank_hit;
   wire no_match = (match == 4'b0000);
   wire one_match = ~no_match &
      ((match & (match - 4'b0001)) == 4'b0000);

   ////////////////////////////////////////////////////////////////////////
   // Cycle sequencer

   cs_unit_pkg::cyc_state_t state;
   cs_unit_pkg::cyc_state_t next_state;
   logic [NB-1:0] sel;
   logic external;
   logic wr_cyc;
   logic [WSW-1:0] wait_cnt;
   logic use_ready;
   logic aa_on;

   // Index of the single matching bank
   logic [1:0] bank_ix;
   always_comb begin
      bank_ix = 2'd0;
      for (int i = NB - 1; i >= 0; i--) begin
         if (match[i]) begin
            bank_ix = 2'(i);
         end
      end
   end

   wire [15:0] ctrl_sel = bank_control_register[bank_ix];
   wire ready_bank = (bank_ix == 2'(cs_unit_pkg::IDE_BANK)) |
                     (bank_ix == 2'(cs_unit_pkg::CARD_BANK));
   wire start_ok = (state == cs_unit_pkg::ST_IDLE) & bus_start_i;
   wire ta_seen = ~transfer_acknowledge_pin_n_i;

   // Auto acknowledge: waits elapsed, plus ready for AT-bus banks.
   // Without auto acknowledge or on multi-match, only the pin ends it.
   wire internal_end = aa_on & ~external & (wait_cnt == '0) &
                       (~use_ready | ready_i);
   wire cyc_end = (state == cs_unit_pkg::ST_ACTIVE) &
                  (internal_end | ((external | ~aa_on) & ta_seen));

   always_comb begin
      next_state = state;
      case (state)
         cs_unit_pkg::ST_IDLE: begin
            if (start_ok && !no_match) begin
               next_state = cs_unit_pkg::ST_ACTIVE;
            end
         end
         cs_unit_pkg::ST_ACTIVE: begin
            if (cyc_end) begin
               next_state = cs_unit_pkg::ST_DONE;
            end
         end
         cs_unit_pkg::ST_DONE: begin
            next_state = cs_unit_pkg::ST_IDLE;
         end
         default: begin
            next_state = cs_unit_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state <= cs_unit_pkg::ST_IDLE;
         sel <= 4'b0000;
         external <= 1'b0;
         wr_cyc <= 1'b0;
         wait_cnt <= '0;
         use_ready <= 1'b0;
         aa_on <= 1'b0;
         port_width_o <= 2'b00;
      end else begin
         state <= next_state;
         if (start_ok && !no_match) begin
            sel <= match;
            external <= ~one_match;
            wr_cyc <= bus_write_i;
            wait_cnt <= ctrl_sel[cs_unit_pkg::CTRL_WS_LO +: WSW];
            aa_on <= ctrl_sel[cs_unit_pkg::CTRL_AA_BIT];
            use_ready <= ready_bank & ata_config_one[cs_unit_pkg::CFG_READY_LO
                         - cs_unit_pkg::IDE_BANK + bank_ix];
            port_width_o <= ctrl_sel[cs_unit_pkg::CTRL_PS_LO +: 2];
         end else if (state == cs_unit_pkg::ST_ACTIVE) begin
            if (wait_cnt != '0) begin
               wait_cnt <= wait_cnt - 1'b1;
            end
            if (cyc_end) begin
               sel <= 4'b0000;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cycle_done_o <= 1'b0;
         cycle_error_o <= 1'b0;
      end else begin
         cycle_done_o <= cyc_end;
         cycle_error_o <= start_ok & no_match;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin outputs

   wire active = (state == cs_unit_pkg::ST_ACTIVE) & ~cyc_end;
   wire [NB-1:0] next_sel = (start_ok && !no_match) ? match :
                            (active ? sel : 4'b0000);
   wire next_wr = start_ok ? bus_write_i : wr_cyc;
   wire ide_split = ata_config_one[cs_unit_pkg::CFG_IDE_SPLIT_BIT];
   wire card_split = ata_config_one[cs_unit_pkg::CFG_CARD_SPLIT_BIT];
   wire [2:0] buf1_en = ata_config_one[cs_unit_pkg::CFG_BUF1_LO +: 3];
   wire [2:0] buf2_en = ata_config_one[cs_unit_pkg::CFG_BUF2_LO +: 3];
   wire next_buf1 = next_sel[0] | (|(next_sel[3:1] & buf1_en));
   wire next_buf2 = ~next_sel[0] & (|(next_sel[3:1] & buf2_en));

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         boot_select_n_o <= 1'b1;
         second_select_n_o <= 1'b1;
         ide_bank_select_n_o <= 1'b1;
         card_bank_select_n_o <= 1'b1;
         ide_read_strobe_n_o <= 1'b1;
         ide_write_strobe_n_o <= 1'b1;
         card_read_strobe_n_o <= 1'b1;
         card_write_strobe_n_o <= 1'b1;
         first_buffer_enable_n_o <= 1'b1;
         second_buffer_enable_n_o <= 1'b1;
      end else begin
         boot_select_n_o <= ~next_sel[0];
         second_select_n_o <= ~next_sel[1];
         ide_bank_select_n_o <= ~next_sel[2];
         card_bank_select_n_o <= ~next_sel[3];
         ide_read_strobe_n_o <= ~(next_sel[2] &
                                  (~next_wr | ~ide_split));
         ide_write_strobe_n_o <= ~(next_sel[2] & next_wr & ide_split);
         card_read_strobe_n_o <= ~(next_sel[3] &
                                   (~next_wr | ~card_split));
         card_write_strobe_n_o <= ~(next_sel[3] & next_wr & card_split);
         first_buffer_enable_n_o <= ~next_buf1;
         second_buffer_enable_n_o <= ~next_buf2;
      end
   end

   // Falling-edge flop gives half a cycle of setup before the memory drives
   always_ff @(negedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         read_oe_n_o <= 1'b1;
      end else begin
         read_oe_n_o <= ~(active & ~wr_cyc & (|sel));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   AST_GLOBAL_BOOT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      boot_global && start_ok |=> !boot_select_n_o && second_select_n_o
      && ide_bank_select_n_o && card_bank_select_n_o)
      else $error("global mode did not select boot bank only");

   AST_NO_MATCH_ERR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      start_ok && no_match |=> cycle_error_o && state == cs_unit_pkg::ST_IDLE)
      else $error("unmatched cycle did not end in error");

   AST_MULTI_EXT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      start_ok && !no_match && !one_match |=> external
      ##0 (state == cs_unit_pkg::ST_ACTIVE))
      else $error("multiple match not taken external");

   AST_EXT_WAITS_TA: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      state == cs_unit_pkg::ST_ACTIVE && external && transfer_acknowledge_pin_n_i
      |=> !cycle_done_o)
      else $error("external cycle ended without acknowledge");

   AST_AA_WAITS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      start_ok && one_match && ctrl_sel[cs_unit_pkg::CTRL_AA_BIT]
      && !ready_bank && ctrl_sel[cs_unit_pkg::CTRL_WS_LO +: WSW] == 4'd1
      |=> ##2 cycle_done_o)
      else $error("auto acknowledge wait count wrong");

   AST_READY_HOLD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      state == cs_unit_pkg::ST_ACTIVE && use_ready && !ready_i && !external
      && aa_on |=> !cycle_done_o)
      else $error("ready bank ended while ready low");

   AST_OE_MATCH: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !read_oe_n_o |-> sel != 4'b0000 && !wr_cyc)
      else $error("read enable without a bank match");

   AST_BOOT_BUF: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !boot_select_n_o |-> !first_buffer_enable_n_o
      && second_buffer_enable_n_o)
      else $error("buffer enables wrong on boot cycle");

   AST_SPLIT_WR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !ide_write_strobe_n_o |-> !ide_bank_select_n_o && ide_read_strobe_n_o
      && $past(ide_split))
      else $error("IDE write strobe without split write cycle");

   AST_GLOBAL_STICKY: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !boot_global |=> !boot_global)
      else $error("global mode came back without reset");

endmodule : cs_unit

`default_nettype wire

// [dv/cs_partner.sv]
/*
 * Far-side model: AT-bus peripheral ready line and external acknowledge.
 * Assumes the unit's active-low selects; both lines idle high by pull-up.
 */
`timescale 1ns/1ns
`default_nettype none

module cs_partner (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic [3:0] select_n_i,
   input wire logic [7:0] ready_delay_i,
   input wire logic [7:0] ack_delay_i,
   input wire logic ack_en_i,
   output logic ready_o,
   output logic ack_n_o
);
   logic [7:0] sel_cycles;
   logic selected;

   assign selected = ~&select_n_i;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sel_cycles <= 8'h00;
      end else if (selected && sel_cycles != 8'hFF) begin
         sel_cycles <= sel_cycles + 8'h01;
      end else if (!selected) begin
         sel_cycles <= 8'h00;
      end
   end

   // Slow device holds ready low; released line floats high
   assign ready_o = !selected || (sel_cycles >= ready_delay_i);
   // Only ends a cycle when told to; never acknowledging hangs the bus
   assign ack_n_o = !(ack_en_i && selected && sel_cycles >= ack_delay_i);

endmodule : cs_partner

`default_nettype wire

// [dv/external_chip_select_unit_bench.sv]
/*
 * Self-checking bench for the chip-select unit: APB register access,
 * global boot mode, decode, waits, AT-bus strobes and external ending.
 * Assumes cs_unit and cs_partner; APB byte address is four times index.
 */
`timescale 1ns/1ns
`default_nettype none

module external_chip_select_unit_bench;
   logic clk_sys_i = 1'b0;
   logic resetn_i = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata;
   logic bus_start = 1'b0, bus_write = 1'b0, ready, ack_n, done, err;
   logic [31:0] bus_addr = 32'h0000_0000;
   logic boot_n, second_n, ide_n, card_n, ide_r_n, ide_w_n, card_r_n;
   logic card_w_n, oe_n, buf1_n, buf2_n;
   logic [1:0] pw;
   logic [7:0] ready_delay = 8'h00, ack_delay = 8'h00;
   logic ack_en = 1'b0;
   int miscompares = 0;
   int checks = 0;

   always #2 clk_sys_i = ~clk_sys_i;

   cs_unit cs_unit_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .bus_start_i(bus_start),
      .bus_addr_i(bus_addr), .bus_write_i(bus_write), .ready_i(ready),
      .transfer_acknowledge_pin_n_i(ack_n), .boot_select_n_o(boot_n),
      .second_select_n_o(second_n), .ide_bank_select_n_o(ide_n),
      .card_bank_select_n_o(card_n), .ide_read_strobe_n_o(ide_r_n),
      .ide_write_strobe_n_o(ide_w_n), .card_read_strobe_n_o(card_r_n),
      .card_write_strobe_n_o(card_w_n), .read_oe_n_o(oe_n),
      .first_buffer_enable_n_o(buf1_n), .second_buffer_enable_n_o(buf2_n),
      .port_width_o(pw), .cycle_done_o(done), .cycle_error_o(err));

   cs_partner cs_partner_i (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .select_n_i({card_n, ide_n, second_n, boot_n}),
      .ready_delay_i(ready_delay), .ack_delay_i(ack_delay),
      .ack_en_i(ack_en), .ready_o(ready), .ack_n_o(ack_n));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic end_of_test;
      if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test

   task automatic apb(input logic w, input logic [9:0] idx,
      input logic [31:0] wd, output logic [31:0] rd, output logic se);
      int n;
      @(posedge clk_sys_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) miscompares++;
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [9:0] i, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, i, d, r, e);
   endtask : wr

   function automatic logic [31:0] ctl(input logic [3:0] ws);
      ctl = 32'h0000_0000;
      ctl[cs_unit_pkg::CTRL_WS_LO +: 4] = ws;
      ctl[cs_unit_pkg::CTRL_AA_BIT] = 1'b1;
      ctl[cs_unit_pkg::CTRL_PS_LO +: 2] = cs_unit_pkg::PS_16BIT;
   endfunction : ctl

   // Valid bit goes in last so the bank never hits half programmed
   task automatic prog(input int b, input logic [15:0] base,
      input logic [31:0] mask, input logic [3:0] ws);
      wr(cs_unit_pkg::BASE_IDX[b], {base, 16'h0000});
      wr(cs_unit_pkg::CTRL_IDX[b], ctl(ws));
      wr(cs_unit_pkg::MASK_IDX[b], mask);
   endtask : prog

   // n counts edges after the start edge up to the one raising done
   task automatic cyc(input logic [31:0] a, input logic w,
      output logic [3:0] sel, output logic [3:0] stb,
      output logic [1:0] bf, output logic oe, output int n,
      output logic er);
      @(posedge clk_sys_i);
      bus_start <= 1'b1;
      bus_addr <= a;
      bus_write <= w;
      @(posedge clk_sys_i);
      bus_start <= 1'b0;
      n = 0;
      // Error stands one cycle from the start edge, so look at once
      #1;
      sel = {card_n, ide_n, second_n, boot_n};
      stb = {card_w_n, card_r_n, ide_w_n, ide_r_n};
      bf = {buf2_n, buf1_n};
      oe = oe_n;
      while (done !== 1'b1 && err !== 1'b1 && n < 300) begin
         @(posedge clk_sys_i);
         #1;
         n++;
         if (n == 1) begin
            @(negedge clk_sys_i);
            #1;
            oe = oe_n;
         end
      end
      er = err;
      if (n >= 300) miscompares++;
   endtask : cyc

   ////////////////////////////////////////////////////////////////////////
   logic [31:0] d;
   logic e, oe, er;
   logic [3:0] sel, stb;
   logic [1:0] bf;
   int n;

   task automatic t_reset;
      apb(1'b0, cs_unit_pkg::CTRL_IDX[0], 32'h0, d, e);
      check(d, {16'h0000, cs_unit_pkg::CTRL0_RESET});
      apb(1'b0, cs_unit_pkg::MASK_IDX[0], 32'h0, d, e);
      check(d, 32'h0000_0000);
      apb(1'b0, cs_unit_pkg::CTRL_IDX[1], 32'h0, d, e);
      check(d, 32'h0000_0000);
      apb(1'b1, 10'h3FF, 32'hFFFF_FFFF, d, e);
      check({31'h0, e}, 32'h1);
   endtask : t_reset

   task automatic t_global;
      cyc(32'h5A5A_0000, 1'b0, sel, stb, bf, oe, n, er);
      check(sel, 4'b1110);
      check(bf, 2'b10);
      check(n, 16);
      check(oe, 1'b0);
   endtask : t_global

   task automatic t_bank1;
      prog(1, 16'h1000, 32'h0001_0001, 4'h1);
      cyc(32'h1001_0000, 1'b1, sel, stb, bf, oe, n, er);
      check(sel, 4'b1110);
      prog(0, 16'h0000, 32'h0000_0001, 4'hF);
      cyc(32'h1001_0000, 1'b1, sel, stb, bf, oe, n, er);
      check(sel, 4'b1101);
      check(n, 2);
      check(pw, cs_unit_pkg::PS_16BIT);
      check(bf, 2'b11);
      apb(1'b0, cs_unit_pkg::CTRL_IDX[1], 32'h0, d, e);
      check(d, ctl(4'h1));
      cyc(32'h3000_0000, 1'b0, sel, stb, bf, oe, n, er);
      check({oe, er, n[7:0]}, {2'b11, 8'h00});
   endtask : t_bank1

   task automatic t_ide;
      d = 32'h0000_0000;
      d[cs_unit_pkg::CFG_IDE_SPLIT_BIT] = 1'b1;
      d[cs_unit_pkg::CFG_BUF2_LO + 1] = 1'b1;
      d[cs_unit_pkg::CFG_READY_LO] = 1'b1;
      wr(cs_unit_pkg::ATA_CFG_IDX, d);
      prog(2, 16'h2000, 32'h0000_0001, 4'h0);
      ready_delay <= 8'd20;
      cyc(32'h2000_0000, 1'b0, sel, stb, bf, oe, n, er);
      check(sel, 4'b1011);
      check(stb, 4'b1110);
      check(bf, 2'b01);
      check(n >= 21, 1'b1);
      cyc(32'h2000_0000, 1'b1, sel, stb, bf, oe, n, er);
      check(stb, 4'b1101);
      ready_delay <= 8'd0;
   endtask : t_ide

   task automatic t_multi;
      prog(3, 16'h1000, 32'h0000_0001, 4'h0);
      ack_delay <= 8'd30;
      ack_en <= 1'b1;
      cyc(32'h1000_0000, 1'b0, sel, stb, bf, oe, n, er);
      check({er, n > 30}, 2'b01);
      ack_en <= 1'b0;
   endtask : t_multi

   initial begin
      repeat (6) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      t_reset();
      t_global();
      t_bank1();
      t_ide();
      t_multi();
      end_of_test();
   end

   // Whole run needs under 2000 cycles; a hung cycle ends in cyc after 300 edges, this stops at 12500
   initial begin
      #50000;
      miscompares++;
      end_of_test();
   end

endmodule : external_chip_select_unit_bench

`default_nettype wire
